// file: logic/fcsd_host.sv
// flash command host: drives command sequences onto the flash pins
//
// Notes on behaviour
// - f0 write returns bank to read
// - unlock pair aa then 55
// - all cycles write except reads
// - program: unlocks, a0, then data
// - autoselect: unlocks, 90 bank, then read
// - secured entry: unlocks then 88
// - secured exit: unlocks, 90, 00
// - bypass entry: unlocks then 20
// - bypass program: a0 then data
// - bypass exit: 90 then 00
// - erase: six writes, 10 or 30
// - resume is 30 to bank
// - suspend is b0, up to 20us
`default_nettype none
module fcsd_host
    import fcsd_pkg::*;
(
    input  wire logic              i_ref_clk,    // 200 mhz clock
    input  wire logic              i_rst,        // async reset, high
    input  wire logic              i_req_valid,  // command request
    output logic                   o_req_ready,  // host idle
    input  wire logic [3:0]        i_req_op,     // operation code
    input  wire logic [ADDR_W-1:0] i_req_addr,   // target address
    input  wire logic [DATA_W-1:0] i_req_data,   // program data
    input  wire logic              i_byte_mode,  // byte addressing
    output logic                   o_done,       // sequence finished pulse
    output logic [DATA_W-1:0]      o_rd_data,    // last read data
    output logic                   o_busy,       // device busy, synced
    output logic                   o_suspended,  // erase suspended state
    output logic                   o_bypass,     // bypass mode state
    output logic                   o_erasing,    // sector erase issued, not done
    output logic [ADDR_W-1:0]      o_fl_addr,    // flash address
    output logic [DATA_W-1:0]      o_fl_dq_o,    // flash data out
    output logic                   o_fl_dq_oe,   // flash data drive
    input  wire logic [DATA_W-1:0] i_fl_dq_i,    // flash data in
    output logic                   o_fl_ce_n,    // chip enable, low
    output logic                   o_fl_we_n,    // write strobe, low
    output logic                   o_fl_oe_n,    // output enable, low
    input  wire logic              i_fl_ready_busy_n // ready_busy_n pin
);
    fcsd_state_t       state_q;
    logic [2:0]        idx_q;
    logic [3:0]        op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic [7:0]        cnt_q;
    logic              step_last;
    logic              step_rd;
    logic [ADDR_W-1:0] step_addr;
    logic [DATA_W-1:0] step_data;
    logic              rb_meta_q;
    logic              rb_sync_q;
    logic [DATA_W-1:0] dq_meta_q;
    logic [DATA_W-1:0] dq_sync_q;
    logic              accept;
    logic              legal;
    logic              cnt_done;

    localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC - 1);

    // =====================================
    // legality of a request in the current mode
    function automatic logic op_legal(input logic [3:0] op, input logic byp, input logic sus, input logic ers);
        logic ok;
        ok = 1'b1;
        if (byp)
            ok = (op == OP_BYP_PROG) || (op == OP_BYP_EXIT) || (op == OP_READ);
        else if (op == OP_BYP_PROG || op == OP_BYP_EXIT)
            ok = 1'b0;
        if (op == OP_RESUME)
            ok = sus;
        if (op == OP_SUSPEND)
            ok = ers && !sus;
        return ok;
    endfunction : op_legal

    assign legal       = op_legal(i_req_op, o_bypass, o_suspended, o_erasing);
    assign o_req_ready = (state_q == FCSD_IDLE);
    assign accept      = i_req_valid && o_req_ready && legal;
    assign cnt_done    = (cnt_q == 8'h00);

    fcsd_seq_rom u_rom (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_op       (op_q),
        .i_idx      (idx_q),
        .i_byte_mode(i_byte_mode),
        .i_addr     (addr_q),
        .i_data     (data_q),
        .o_last     (step_last),
        .o_is_read  (step_rd),
        .o_addr     (step_addr),
        .o_data     (step_data)
    );

    // =====================================
    // pin synchronisers
    // ready/busy through two flops
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rb_meta_q <= 1'b1;
            rb_sync_q <= 1'b1;
            dq_meta_q <= '0;
            dq_sync_q <= '0;
        end else begin
            rb_meta_q <= i_fl_ready_busy_n;
            rb_sync_q <= rb_meta_q;
            dq_meta_q <= i_fl_dq_i;
            dq_sync_q <= dq_meta_q;
        end
    end
    assign o_busy = !rb_sync_q;

    // =====================================
    // sequencer
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= FCSD_IDLE;
            idx_q   <= 3'd0;
            op_q    <= OP_READ;
            addr_q  <= '0;
            data_q  <= '0;
            cnt_q   <= 8'h00;
        end else begin
            cnt_q <= cnt_done ? 8'h00 : cnt_q - 8'h01;
            case (state_q)
                FCSD_IDLE: begin
                    if (accept) begin
                        op_q    <= i_req_op;
                        addr_q  <= i_req_addr;
                        data_q  <= i_req_data;
                        idx_q   <= 3'd0;
                        state_q <= FCSD_LOAD;
                    end
                end
                FCSD_LOAD: begin
                    cnt_q   <= STROBE_CNT;
                    state_q <= FCSD_SETUP;
                end
                FCSD_SETUP: begin
                    cnt_q   <= STROBE_CNT;
                    state_q <= FCSD_PULSE;
                end
                FCSD_PULSE: begin
                    if (cnt_done) begin
                        cnt_q   <= STROBE_CNT;
                        state_q <= FCSD_HOLD;
                    end
                end
                // data held past the rising strobe
                FCSD_HOLD: begin
                    if (cnt_done)
                        state_q <= step_last ? FCSD_WAIT : FCSD_NEXT;
                end
                FCSD_NEXT: begin
                    idx_q   <= idx_q + 3'd1;
                    state_q <= FCSD_LOAD;
                end
                FCSD_WAIT: begin
                    state_q <= FCSD_IDLE;
                end
                default: begin
                    state_q <= FCSD_IDLE;
                end
            endcase
        end
    end

    // =====================================
    // pin drive
    // only read steps raise output enable
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fl_addr  <= '0;
            o_fl_dq_o  <= '0;
            o_fl_dq_oe <= 1'b0;
            o_fl_ce_n  <= 1'b1;
            o_fl_we_n  <= 1'b1;
            o_fl_oe_n  <= 1'b1;
        end else begin
            if (state_q == FCSD_SETUP) begin
                o_fl_addr  <= step_addr;
                o_fl_dq_o  <= step_data;
                o_fl_dq_oe <= !step_rd;
                o_fl_ce_n  <= 1'b0;
            end
            if (state_q == FCSD_SETUP && cnt_done)
                o_fl_ce_n <= 1'b0;
            o_fl_we_n <= !((state_q == FCSD_PULSE) && !step_rd);
            o_fl_oe_n <= !((state_q == FCSD_PULSE || state_q == FCSD_HOLD) && step_rd);
            if (state_q == FCSD_WAIT || state_q == FCSD_NEXT) begin
                o_fl_ce_n  <= 1'b1;
                o_fl_dq_oe <= 1'b0;
            end
        end
    end

    // =====================================
    // read capture and done pulse
    // read data returned to user
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= '0;
            o_done    <= 1'b0;
        end else begin
            o_done <= (state_q == FCSD_WAIT);
            if (state_q == FCSD_HOLD && cnt_done && step_rd)
                o_rd_data <= dq_sync_q;
        end
    end

    // =====================================
    // mode tracking
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bypass    <= 1'b0;
            o_suspended <= 1'b0;
            o_erasing   <= 1'b0;
        end else if (state_q == FCSD_WAIT) begin
            if (op_q == OP_BYP_ENTER)
                o_bypass <= 1'b1;
            if (op_q == OP_BYP_EXIT)
                o_bypass <= 1'b0;
            if (op_q == OP_SECT_ERASE)
                o_erasing <= 1'b1;
            if (op_q == OP_SUSPEND)
                o_suspended <= 1'b1;
            if (op_q == OP_RESUME)
                o_suspended <= 1'b0;
        end else if (o_erasing && !o_suspended && rb_sync_q && state_q == FCSD_IDLE && !i_req_valid) begin
            // erase finished once ready seen idle
            o_erasing <= 1'b0;
        end
    end

    // =====================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    we_oe_excl_a: assert property (!(!o_fl_we_n && !o_fl_oe_n))
        else $error("write and read strobes both low");
    we_needs_ce_a: assert property (!o_fl_we_n |-> !o_fl_ce_n)
        else $error("write strobe without chip enable");
    addr_stable_a: assert property (!o_fl_we_n && $past(!o_fl_we_n) |-> $stable(o_fl_addr))
        else $error("address moved during write pulse");
    data_hold_a: assert property ($rose(o_fl_we_n) |-> $stable(o_fl_dq_o) && o_fl_dq_oe)
        else $error("data not held at rising strobe");
    drive_on_write_a: assert property (!o_fl_we_n |-> o_fl_dq_oe)
        else $error("write without data drive");
    no_bypass_prog_a: assert property (state_q == FCSD_LOAD && op_q == OP_BYP_PROG && idx_q == 3'd0
                                       |-> o_bypass)
        else $error("bypass program outside bypass mode");
    resume_legal_a: assert property (state_q == FCSD_LOAD && op_q == OP_RESUME |-> o_suspended)
        else $error("resume while not suspended");
    suspend_legal_a: assert property (state_q == FCSD_LOAD && op_q == OP_SUSPEND |-> o_erasing)
        else $error("suspend without sector erase");
    done_after_wait_a: assert property (state_q == FCSD_WAIT |=> o_done ##1 !o_done)
        else $error("done pulse malformed");

    prog_cov: cover property (o_done && op_q == OP_PROGRAM);
    erase_cov: cover property (o_done && op_q == OP_SECT_ERASE);
    suspend_cov: cover property (o_done && op_q == OP_SUSPEND);
    autosel_cov: cover property (o_done && op_q == OP_AUTOSEL);
endmodule : fcsd_host
`default_nettype wire

// file: logic/fcsd_pkg.sv
// package: command codes, addresses and timing for the flash command host
`default_nettype none
package fcsd_pkg;
    localparam int          ADDR_W         = 21;
    localparam int          DATA_W         = 16;
    localparam logic [7:0]  CMD_UNLOCK1    = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK2    = 8'h55;
    localparam logic [7:0]  CMD_RESET      = 8'hf0;
    localparam logic [7:0]  CMD_AUTOSEL    = 8'h90;
    localparam logic [7:0]  CMD_SECURED    = 8'h88;
    localparam logic [7:0]  CMD_PROGRAM    = 8'ha0;
    localparam logic [7:0]  CMD_BYPASS     = 8'h20;
    localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0]  CMD_SECT_ERASE = 8'h30;
    localparam logic [7:0]  CMD_SUSPEND    = 8'hb0;
    localparam logic [7:0]  CMD_RESUME     = 8'h30;
    localparam logic [7:0]  CMD_CFI        = 8'h98;
    localparam logic [7:0]  CMD_ZERO       = 8'h00;
    localparam logic [11:0] WORD_UNLOCK_A  = 12'h555;
    localparam logic [11:0] WORD_UNLOCK_B  = 12'h2aa;
    localparam logic [11:0] BYTE_UNLOCK_A  = 12'haaa;
    localparam logic [11:0] BYTE_UNLOCK_B  = 12'h555;
    localparam logic [11:0] WORD_CFI_ADDR  = 12'h055;
    localparam logic [11:0] BYTE_CFI_ADDR  = 12'h0aa;
    localparam logic [7:0]  ID_MAKER_OFS   = 8'h00;
    localparam logic [7:0]  ID_DEV_W_OFS   = 8'h01;
    localparam logic [7:0]  ID_DEV_B_OFS   = 8'h02;
    localparam logic [7:0]  ID_LOCK_W_OFS  = 8'h03;
    localparam logic [7:0]  ID_LOCK_B_OFS  = 8'h06;
    localparam logic [7:0]  ID_PROT_W_OFS  = 8'h02;
    localparam logic [7:0]  ID_PROT_B_OFS  = 8'h04;
    localparam logic [7:0]  LOCKED_CODE    = 8'h81;
    localparam logic [7:0]  UNPROT_CODE    = 8'h00;
    localparam int          CLK_MHZ        = 200;
    localparam int          STROBE_NS      = 40;
    localparam int          STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int          SUSPEND_US     = 20;
    localparam int          SUSPEND_CYC    = SUSPEND_US * CLK_MHZ;
    localparam int          TIMER_W        = 16;
    localparam int          SEQ_LEN        = 8;
    localparam logic [3:0]  OP_READ        = 4'h0;
    localparam logic [3:0]  OP_RESET       = 4'h1;
    localparam logic [3:0]  OP_AUTOSEL     = 4'h2;
    localparam logic [3:0]  OP_SEC_ENTER   = 4'h3;
    localparam logic [3:0]  OP_SEC_EXIT    = 4'h4;
    localparam logic [3:0]  OP_PROGRAM     = 4'h5;
    localparam logic [3:0]  OP_BYP_ENTER   = 4'h6;
    localparam logic [3:0]  OP_BYP_PROG    = 4'h7;
    localparam logic [3:0]  OP_BYP_EXIT    = 4'h8;
    localparam logic [3:0]  OP_CHIP_ERASE  = 4'h9;
    localparam logic [3:0]  OP_SECT_ERASE  = 4'ha;
    localparam logic [3:0]  OP_SUSPEND     = 4'hb;
    localparam logic [3:0]  OP_RESUME      = 4'hc;
    localparam logic [3:0]  OP_CFI         = 4'hd;
    typedef enum logic [2:0] {
        FCSD_IDLE  = 3'b000,
        FCSD_LOAD  = 3'b001,
        FCSD_SETUP = 3'b011,
        FCSD_PULSE = 3'b010,
        FCSD_HOLD  = 3'b110,
        FCSD_NEXT  = 3'b111,
        FCSD_WAIT  = 3'b101
    } fcsd_state_t;
    typedef struct packed {
        logic                  is_read;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     data;
    } fcsd_step_t;
endpackage : fcsd_pkg
`default_nettype wire

// file: logic/fcsd_seq_rom.sv
// small step memory: expands an operation into its bus cycles
`default_nettype none
module fcsd_seq_rom
    import fcsd_pkg::*;
(
    input  wire logic              i_ref_clk,   // system clock
    input  wire logic              i_rst,       // async reset, high
    input  wire logic [3:0]        i_op,        // operation code
    input  wire logic [2:0]        i_idx,       // step index
    input  wire logic              i_byte_mode, // byte addressing
    input  wire logic [ADDR_W-1:0] i_addr,      // user address
    input  wire logic [DATA_W-1:0] i_data,      // user data
    output logic                   o_last,      // step is final
    output logic                   o_is_read,   // step is a read
    output logic [ADDR_W-1:0]      o_addr,      // step address
    output logic [DATA_W-1:0]      o_data       // step data
);
    fcsd_step_t step;
    logic       last;
    logic [11:0] ua;
    logic [11:0] ub;

    function automatic fcsd_step_t mk(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        fcsd_step_t s;
        s.is_read = rd;
        s.addr    = a;
        s.data    = {8'h00, d};
        return s;
    endfunction : mk

    // =====================================
    // step table
    always_comb begin
        ua   = i_byte_mode ? BYTE_UNLOCK_A : WORD_UNLOCK_A;
        ub   = i_byte_mode ? BYTE_UNLOCK_B : WORD_UNLOCK_B;
        step = mk(1'b0, {9'h000, ua}, CMD_UNLOCK1);
        last = 1'b0;
        if (i_idx == 3'd1)
            step = mk(1'b0, {9'h000, ub}, CMD_UNLOCK2);
        case (i_op)
            OP_READ: begin
                step = mk(1'b1, i_addr, 8'h00);
                last = 1'b1;
            end
            OP_RESET: begin
                step = mk(1'b0, i_addr, CMD_RESET);
                last = 1'b1;
            end
            OP_AUTOSEL: begin
                if (i_idx == 3'd2)
                    step = mk(1'b0, {i_addr[ADDR_W-1:12], ua}, CMD_AUTOSEL);
                if (i_idx == 3'd3) begin
                    step = mk(1'b1, i_addr, 8'h00);
                    last = 1'b1;
                end
            end
            OP_SEC_ENTER, OP_BYP_ENTER: begin
                if (i_idx == 3'd2) begin
                    step = mk(1'b0, {9'h000, ua}, (i_op == OP_SEC_ENTER) ? CMD_SECURED : CMD_BYPASS);
                    last = 1'b1;
                end
            end
            OP_SEC_EXIT: begin
                if (i_idx == 3'd2)
                    step = mk(1'b0, {9'h000, ua}, CMD_AUTOSEL);
                if (i_idx == 3'd3) begin
                    step = mk(1'b0, i_addr, CMD_ZERO);
                    last = 1'b1;
                end
            end
            OP_PROGRAM: begin
                if (i_idx == 3'd2)
                    step = mk(1'b0, {9'h000, ua}, CMD_PROGRAM);
                if (i_idx == 3'd3) begin
                    step.is_read = 1'b0;
                    step.addr    = i_addr;
                    step.data    = i_data;
                    last         = 1'b1;
                end
            end
            OP_BYP_PROG: begin
                step = mk(1'b0, i_addr, CMD_PROGRAM);
                if (i_idx == 3'd1) begin
                    step.addr = i_addr;
                    step.data = i_data;
                    last      = 1'b1;
                end
            end
            OP_BYP_EXIT: begin
                step = mk(1'b0, i_addr, (i_idx == 3'd0) ? CMD_AUTOSEL : CMD_ZERO);
                last = (i_idx == 3'd1);
            end
            OP_CHIP_ERASE, OP_SECT_ERASE: begin
                if (i_idx == 3'd2)
                    step = mk(1'b0, {9'h000, ua}, CMD_ERASE_SET);
                if (i_idx == 3'd4)
                    step = mk(1'b0, {9'h000, ub}, CMD_UNLOCK2);
                if (i_idx == 3'd5) begin
                    step = (i_op == OP_CHIP_ERASE) ? mk(1'b0, {9'h000, ua}, CMD_CHIP_ERASE)
                                                   : mk(1'b0, i_addr, CMD_SECT_ERASE);
                    last = 1'b1;
                end
            end
            OP_SUSPEND, OP_RESUME: begin
                step = mk(1'b0, i_addr, (i_op == OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME);
                last = 1'b1;
            end
            OP_CFI: begin
                step = mk(1'b0, {9'h000, i_byte_mode ? BYTE_CFI_ADDR : WORD_CFI_ADDR}, CMD_CFI);
                last = 1'b1;
            end
            default: begin
                step = mk(1'b0, i_addr, CMD_RESET);
                last = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_last    <= 1'b0;
            o_is_read <= 1'b0;
            o_addr    <= '0;
            o_data    <= '0;
        end else begin
            o_last    <= last;
            o_is_read <= step.is_read;
            o_addr    <= step.addr;
            o_data    <= step.data;
        end
    end
endmodule : fcsd_seq_rom
`default_nettype wire

// file: sim/fcsd_flash_model.sv
// flash device model: logs write cycles, answers reads, drives ready_busy_n
`default_nettype none
module fcsd_flash_model
    import fcsd_pkg::*;
#(
    parameter logic [7:0] MAKER = 8'h3c // arbitrary value
) (
    input  wire logic [ADDR_W-1:0] i_a,    // address pins
    input  wire logic [DATA_W-1:0] i_dq,   // data wire
    input  wire logic              i_bm,   // byte mode
    input  wire logic              i_ce_n, // chip enable
    input  wire logic              i_we_n, // write strobe
    input  wire logic              i_oe_n, // output enable
    output logic [DATA_W-1:0]      o_dq,   // read drive
    output logic                   o_ready_busy_n // status pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ADDR_W-1:0] wa[$];
    logic [DATA_W-1:0] wd[$];
    logic [DATA_W-1:0] mem[int];
    logic [ADDR_W-1:0] la;
    logic              wr = 1'b0;
    logic              asel = 1'b0;
    time               bz = 0;
    initial o_dq = 16'h5a5a;
    function automatic logic [7:0] idv(input logic [7:0] o);
        if (o == ID_MAKER_OFS) return MAKER;
        return (o == (i_bm ? ID_LOCK_B_OFS : ID_LOCK_W_OFS)) ? LOCKED_CODE : UNPROT_CODE;
    endfunction : idv
    always @(negedge i_we_n or negedge i_ce_n) begin
        if (!i_we_n && !i_ce_n) begin
            wr = 1'b1;
            la = i_a;
        end
    end
    always @(posedge i_we_n or posedge i_ce_n) begin
        if (wr) begin
            wr = 1'b0;
            wa.push_back(la);
            wd.push_back(i_dq);
            if (i_dq[7:0] == CMD_RESET || (i_dq[7:0] == CMD_ZERO && wd[$-1][7:0] == CMD_AUTOSEL)) asel = 1'b0;
            if (i_dq[7:0] == CMD_AUTOSEL && wd[$-1][7:0] == CMD_UNLOCK2) asel = 1'b1;
            if (i_dq[7:0] inside {CMD_CHIP_ERASE, CMD_SECT_ERASE}) bz = $time + 2000;
            if (i_dq[7:0] == CMD_SUSPEND) bz = $time;
            if (wd[$-1][7:0] == CMD_PROGRAM) begin
                mem[int'(la)] = i_dq;
                bz = $time + 500;
            end
        end
    end
    always #1 o_ready_busy_n = ($time >= bz);
    // array or autoselect reads; released bus keeps changing
    always @(i_ce_n or i_oe_n or i_a or asel) begin
        if (!i_ce_n && !i_oe_n) o_dq = asel ? DATA_W'(idv(i_a[7:0]))
            : (mem.exists(int'(i_a)) ? mem[int'(i_a)] : ~i_a[15:0]);
        else o_dq = ~o_dq;
    end
endmodule : fcsd_flash_model
`default_nettype wire

// file: sim/fcsd_host_tb_top.sv
// testbench: flash command host against the flash model
`default_nettype none
module fcsd_host_tb_top
    import fcsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
    localparam logic [ADDR_W-1:0] AM = 21'h0007ff;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_req_valid = 1'b0;
    logic i_byte_mode = 1'b0;
    logic [3:0] i_req_op = OP_READ;
    logic [ADDR_W-1:0] i_req_addr = '0;
    logic [DATA_W-1:0] i_req_data = '0;
    logic [DATA_W-1:0] i_fl_dq_i, o_fl_dq_o, o_rd_data, m_dq;
    logic [ADDR_W-1:0] o_fl_addr;
    logic o_req_ready, o_done, o_busy, o_suspended, o_bypass, o_erasing;
    logic o_fl_dq_oe, o_fl_ce_n, o_fl_we_n, o_fl_oe_n, i_fl_ready_busy_n;
    logic [ADDR_W-1:0] ea[$], em[$];
    logic [DATA_W-1:0] ed[$];
    logic [31:0] seed = 32'h05f674b4;
    int n_mismatch = 0;
    int n_tests = 0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    assign i_fl_dq_i = o_fl_dq_oe ? o_fl_dq_o : m_dq;
    fcsd_host fcsd_host_i (.i_ref_clk, .i_rst, .i_req_valid, .o_req_ready, .i_req_op, .i_req_addr,
        .i_req_data, .i_byte_mode, .o_done, .o_rd_data, .o_busy, .o_suspended, .o_bypass, .o_erasing,
        .o_fl_addr, .o_fl_dq_o, .o_fl_dq_oe, .i_fl_dq_i, .o_fl_ce_n, .o_fl_we_n, .o_fl_oe_n, .i_fl_ready_busy_n);
    fcsd_flash_model #(.MAKER(MAKER)) fcsd_flash_model_i (.i_a(o_fl_addr), .i_dq(i_fl_dq_i), .i_bm(i_byte_mode),
        .i_ce_n(o_fl_ce_n), .i_we_n(o_fl_we_n), .i_oe_n(o_fl_oe_n), .o_dq(m_dq), .o_ready_busy_n(i_fl_ready_busy_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic push(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] m, input logic [7:0] c);
        ea.push_back(a);
        em.push_back(m);
        ed.push_back({8'h00, c});
    endtask : push
    // expected write cycles of one operation
    task automatic expect_op(input logic [3:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] ua, ub;
        ua = ADDR_W'(i_byte_mode ? BYTE_UNLOCK_A : WORD_UNLOCK_A);
        ub = ADDR_W'(i_byte_mode ? BYTE_UNLOCK_B : WORD_UNLOCK_B);
        ea.delete();
        em.delete();
        ed.delete();
        if (op inside {OP_AUTOSEL, OP_SEC_ENTER, OP_SEC_EXIT, OP_PROGRAM, OP_BYP_ENTER,
            OP_CHIP_ERASE, OP_SECT_ERASE}) begin
            push(ua, AM, CMD_UNLOCK1);
            push(ub, AM, CMD_UNLOCK2);
        end
        case (op)
            OP_RESET: push(a, '0, CMD_RESET);
            OP_AUTOSEL, OP_SEC_EXIT: push(ua, AM, CMD_AUTOSEL);
            OP_SEC_ENTER: push(ua, AM, CMD_SECURED);
            OP_PROGRAM: push(ua, AM, CMD_PROGRAM);
            OP_BYP_ENTER: push(ua, AM, CMD_BYPASS);
            OP_BYP_PROG: push(a, '0, CMD_PROGRAM);
            OP_BYP_EXIT: push(a, '0, CMD_AUTOSEL);
            OP_SUSPEND: push(a, '0, CMD_SUSPEND);
            OP_RESUME: push(a, '0, CMD_RESUME);
            OP_CFI: push(ADDR_W'(i_byte_mode ? BYTE_CFI_ADDR : WORD_CFI_ADDR), AM, CMD_CFI);
            OP_CHIP_ERASE, OP_SECT_ERASE: begin
                push(ua, AM, CMD_ERASE_SET);
                push(ua, AM, CMD_UNLOCK1);
                push(ub, AM, CMD_UNLOCK2);
            end
            default: ;
        endcase
        if (op inside {OP_PROGRAM, OP_BYP_PROG}) push(a, '1, d[7:0]);
        if (op inside {OP_PROGRAM, OP_BYP_PROG}) ed[$] = d;
        if (op inside {OP_SEC_EXIT, OP_BYP_EXIT}) push(a, '0, CMD_ZERO);
        if (op == OP_CHIP_ERASE) push(ua, AM, CMD_CHIP_ERASE);
        if (op == OP_SECT_ERASE) push(a, 21'h1ff000, CMD_SECT_ERASE);
    endtask : expect_op
    task automatic run_op(input logic [3:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        expect_op(op, a, d);
        fcsd_flash_model_i.wa.delete();
        fcsd_flash_model_i.wd.delete();
        i_req_op = op;
        i_req_addr = a;
        i_req_data = d;
        i_req_valid = 1'b1;
        @(posedge i_ref_clk);
        #1;
        i_req_valid = 1'b0;
        for (k = 0; k < 600 && o_done !== 1'b1; k++) begin
            @(posedge i_ref_clk);
            #1;
        end
        chk("done", 32'd1, 32'(o_done));
        if (o_done !== 1'b1) print_verdict();
        chk("writes", ea.size(), fcsd_flash_model_i.wa.size());
        for (k = 0; k < ea.size() && k < fcsd_flash_model_i.wa.size(); k++) begin
            chk("address", ea[k] & em[k], fcsd_flash_model_i.wa[k] & em[k]);
            chk("data", ed[k], fcsd_flash_model_i.wd[k]);
        end
    endtask : run_op
    task automatic refuse(input logic [3:0] op);
        fcsd_flash_model_i.wa.delete();
        i_req_op = op;
        i_req_valid = 1'b1;
        repeat (40) @(posedge i_ref_clk);
        #1;
        i_req_valid = 1'b0;
        chk("refused", 0, fcsd_flash_model_i.wa.size());
        chk("ready", 1, 32'(o_req_ready));
    endtask : refuse
    task automatic idle_wait();
        int k;
        for (k = 0; k < 2000 && {o_busy, o_erasing} !== 2'b00; k++) begin
            @(posedge i_ref_clk);
            #1;
        end
        chk("idle", 0, {o_busy, o_erasing});
        if (k == 2000) print_verdict();
    endtask : idle_wait
    initial begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        int p;
        repeat (12) @(posedge i_ref_clk);
        #1;
        i_rst = 1'b0;
        for (p = 0; p < 3; p++) begin
            i_byte_mode = p[0];
            a = ADDR_W'(rnd());
            d = DATA_W'(rnd());
            refuse(OP_BYP_PROG);
            refuse(OP_RESUME);
            run_op(OP_AUTOSEL, {a[20:8], ID_MAKER_OFS}, '0);
            chk("maker", MAKER, o_rd_data);
            run_op(OP_AUTOSEL, {a[20:8], p[0] ? ID_LOCK_B_OFS : ID_LOCK_W_OFS}, '0);
            chk("lock", LOCKED_CODE, o_rd_data);
            run_op(OP_RESET, a, '0);
            run_op(OP_SEC_ENTER, a, '0);
            run_op(OP_SEC_EXIT, a, '0);
            run_op(OP_CFI, a, '0);
            run_op(OP_PROGRAM, a, d);
            chk("busy", 1, 32'(o_busy));
            run_op(OP_READ, a, '0);
            chk("read", d, o_rd_data);
            run_op(OP_BYP_ENTER, a, '0);
            chk("bypass", 1, 32'(o_bypass));
            refuse(OP_PROGRAM);
            run_op(OP_BYP_PROG, ADDR_W'(rnd()), DATA_W'(rnd()));
            run_op(OP_BYP_EXIT, a, '0);
            chk("bypass", 0, 32'(o_bypass));
            idle_wait();
            run_op(OP_SECT_ERASE, a, '0);
            chk("erasing", 1, 32'(o_erasing));
            run_op(OP_SUSPEND, a, '0);
            chk("suspended", 1, 32'(o_suspended));
            run_op(OP_RESUME, a, '0);
            chk("suspended", 0, 32'(o_suspended));
            idle_wait();
            run_op(OP_CHIP_ERASE, a, '0);
            idle_wait();
            $display("pass %0d ended", p);
        end
        print_verdict();
    end
endmodule : fcsd_host_tb_top
`default_nettype wire
